// ### rtl/bp_pkg.sv
// Purpose: shared constants for the breakpoint match unit
// Assumes: 32-bit addresses and data, registers on 4-byte offsets, bound word indices numbered separately
// Notes:   offsets are local to the block's register window
package bp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int RADDR_W = 8;
    localparam int PORTS = 2;

    // register byte offsets
    localparam logic [RADDR_W-1:0] OFS_INSTR_CTRL = 8'h00;
    localparam logic [RADDR_W-1:0] OFS_INSTR_LOW  = 8'h04;
    localparam logic [RADDR_W-1:0] OFS_INSTR_HIGH = 8'h08;
    localparam logic [RADDR_W-1:0] OFS_DATA_CTRL  = 8'h10;
    localparam logic [RADDR_W-1:0] OFS_DATA_LOW   = 8'h14;
    localparam logic [RADDR_W-1:0] OFS_DATA_HIGH  = 8'h18;
    localparam logic [RADDR_W-1:0] OFS_DATA_VALUE = 8'h1C;
    localparam logic [RADDR_W-1:0] OFS_DATA_MASK  = 8'h20;
    localparam logic [RADDR_W-1:0] OFS_MATCH_CNT  = 8'h24;
    localparam int NUM_BOUND_REGS = 6;

    // bound memory word indices
    localparam logic [2:0] IDX_INSTR_LOW  = 3'h0;
    localparam logic [2:0] IDX_INSTR_HIGH = 3'h1;
    localparam logic [2:0] IDX_DATA_LOW   = 3'h2;
    localparam logic [2:0] IDX_DATA_HIGH  = 3'h3;
    localparam logic [2:0] IDX_DATA_VALUE = 3'h4;
    localparam logic [2:0] IDX_DATA_MASK  = 3'h5;

    // instruction control fields
    localparam int INSTR_ENABLE_BIT = 0;
    localparam int INSTR_INVERT_BIT = 1;
    localparam int INSTR_CTRL_W = 2;
    localparam logic [INSTR_CTRL_W-1:0] INSTR_CTRL_RESET = 2'h0;

    // data control fields
    localparam int DSEL_LSB = 0;
    localparam int DSEL_W = 2;
    localparam int MATCH_LOADS_BIT = 2;
    localparam int MATCH_STORES_BIT = 3;
    localparam int DATA_INVERT_BIT = 4;
    localparam int VALUE_NE_BIT = 5;
    localparam int DATA_CTRL_W = 6;
    localparam logic [DATA_CTRL_W-1:0] DATA_CTRL_RESET = 6'h00;

    // timer source codes
    localparam logic [3:0] SRC_DATA_MATCH = 4'h3;
    localparam logic [3:0] SRC_INSTR_MATCH = 4'h4;

    typedef enum logic [1:0] {
        SEL_OFF   = 2'h0,
        SEL_ADDR  = 2'h1,
        SEL_VALUE = 2'h2,
        SEL_BOTH  = 2'h3
    } compare_select_type;
endpackage : bp_pkg

// ### rtl/bound_if.sv
// Purpose: carries bound register writes and live values to the matcher
// Assumes: single clock
// Notes:   values come straight out of the bound store registers
`timescale 1ns/1ps
interface bound_if;
    import bp_pkg::*;
    logic                            wr_en;
    logic [2:0]                      wr_idx;
    logic [DATA_W-1:0]               wr_data;
    wire  [NUM_BOUND_REGS*DATA_W-1:0] words; // a net: every word slice has its own driver

    modport store (input wr_en, input wr_idx, input wr_data, output words);
    modport user  (output wr_en, output wr_idx, output wr_data, input words);
endinterface : bound_if

// ### rtl/bound_store.sv
// Purpose: holds the bound, compare value and mask words
// Assumes: writes come from the register decode of the top module
// Notes:   no reset on purpose, contents stay undefined until software loads them
`timescale 1ns/1ps
module bound_store
    import bp_pkg::*;
(
    input  wire logic clk,
    input  wire logic clk_en,
    bound_if.store    bus
);
    logic [DATA_W-1:0] mem_reg [NUM_BOUND_REGS];

    always_ff @(posedge clk) begin
        if (clk_en && bus.wr_en) begin
            mem_reg[bus.wr_idx] <= bus.wr_data;
        end
    end

    // flatten words for parallel comparison
    genvar g;
    generate
        for (g = 0; g < NUM_BOUND_REGS; g++) begin : g_flat
            assign bus.words[g*DATA_W +: DATA_W] = mem_reg[g];
        end
    endgenerate
endmodule : bound_store

// ### rtl/breakpoint_match_unit.sv
// Purpose: breakpoint comparison for instruction fetch and two load/store ports
// Assumes: pipeline inputs are on clk; register port reads answer one cycle later
// Notes:   events are per-cycle counts registered once, feeding the timer source mux
//
// Functional notes
// - instruction compare runs only while instr_bp_enable is 1
// - invert 0 matches inside inclusive range, 1 matches outside
// - each instruction match yields an event usable as timer source
// - reset clears instr_bp_control, breakpoints off
// - instruction bound registers are not reset
// - data compare active when data_compare_select nonzero
// - select 1 or 3 compares addresses of enabled loads and stores
// - data range invert 0 inside inclusive, 1 outside
// - address compare ignores apertures entirely
// - select 2 or 3 compares data of enabled loads and stores
// - only mask bits set to 1 take part in value compare
// - value_not_equal picks equal or not-equal match
// - select 3 needs address and value match on same access
// - each data match yields an event usable as timer source
// - both load/store ports checked every cycle, up to two events
// - reset clears data_bp_control, other data words not reset
// - source 3 counts data matches, source 4 instruction matches
`timescale 1ns/1ps
module breakpoint_match_unit
    import bp_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        clk_en,
    // register port
    input  wire logic [RADDR_W-1:0]          reg_addr,
    input  wire logic [DATA_W-1:0]           reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output logic      [DATA_W-1:0]           reg_rdata,
    // instruction fetch
    input  wire logic                        instr_valid,
    input  wire logic [ADDR_W-1:0]           instr_addr,
    // load/store ports
    input  wire logic [PORTS-1:0]            mem_valid,
    input  wire logic [PORTS-1:0]            mem_is_store,
    input  wire logic [PORTS*ADDR_W-1:0]     mem_addr,
    input  wire logic [PORTS*DATA_W-1:0]     mem_data,
    // timer source selection
    input  wire logic [3:0]                  timer_source,
    output logic [1:0]                       timer_increment,
    // raw events
    output logic                             instr_match_source,
    output logic [1:0]                       data_match_source
);
    import bp_pkg::*;

    logic [INSTR_CTRL_W-1:0] instr_bp_control_reg;
    logic [DATA_CTRL_W-1:0]  data_bp_control_reg;
    logic [DATA_W-1:0]       match_cnt_reg;
    logic [DATA_W-1:0]       match_cnt_next;
    logic                    instr_ev_reg;
    logic [1:0]              data_count_reg;
    logic [DATA_W-1:0]       reg_rdata_reg;

    bound_if bnd ();

    bound_store u_store (
        .clk    (clk),
        .clk_en (clk_en),
        .bus    (bnd)
    );

    // inclusive range test with optional invert
    function automatic logic range_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                       input logic [ADDR_W-1:0] hi, input logic inv);
        logic in_range;
        in_range = (a >= lo) && (a <= hi);
        range_hit = inv ? !in_range : in_range;
    endfunction : range_hit

    // masked value test, equal or not-equal
    function automatic logic value_hit(input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] v,
                                       input logic [DATA_W-1:0] m, input logic ne);
        logic same;
        same = ((d & m) == (v & m));
        value_hit = ne ? !same : same;
    endfunction : value_hit

    // bound words
    wire [ADDR_W-1:0] instr_low  = bnd.words[IDX_INSTR_LOW*DATA_W +: DATA_W];
    wire [ADDR_W-1:0] instr_high = bnd.words[IDX_INSTR_HIGH*DATA_W +: DATA_W];
    wire [ADDR_W-1:0] data_low   = bnd.words[IDX_DATA_LOW*DATA_W +: DATA_W];
    wire [ADDR_W-1:0] data_high  = bnd.words[IDX_DATA_HIGH*DATA_W +: DATA_W];
    wire [DATA_W-1:0] data_compare_value = bnd.words[IDX_DATA_VALUE*DATA_W +: DATA_W];
    wire [DATA_W-1:0] data_compare_mask  = bnd.words[IDX_DATA_MASK*DATA_W +: DATA_W];

    // control fields
    wire instr_bp_enable    = instr_bp_control_reg[INSTR_ENABLE_BIT];
    wire instr_range_invert = instr_bp_control_reg[INSTR_INVERT_BIT];
    wire [DSEL_W-1:0] data_compare_select = data_bp_control_reg[DSEL_LSB +: DSEL_W];
    wire match_loads        = data_bp_control_reg[MATCH_LOADS_BIT];
    wire match_stores       = data_bp_control_reg[MATCH_STORES_BIT];
    wire data_range_invert  = data_bp_control_reg[DATA_INVERT_BIT];
    wire value_not_equal    = data_bp_control_reg[VALUE_NE_BIT];

    wire use_addr  = (data_compare_select == SEL_ADDR) || (data_compare_select == SEL_BOTH);
    wire use_value = (data_compare_select == SEL_VALUE) || (data_compare_select == SEL_BOTH);
    wire data_active = (data_compare_select != SEL_OFF);

    wire instr_hit = instr_bp_enable && instr_valid &&
                     range_hit(instr_addr, instr_low, instr_high, instr_range_invert);

    logic [PORTS-1:0] data_hit;
    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            wire [ADDR_W-1:0] a = mem_addr[p*ADDR_W +: ADDR_W];
            wire [DATA_W-1:0] d = mem_data[p*DATA_W +: DATA_W];
            wire kind_ok = mem_is_store[p] ? match_stores : match_loads;
            wire a_ok = range_hit(a, data_low, data_high, data_range_invert);
            wire v_ok = value_hit(d, data_compare_value, data_compare_mask, value_not_equal);
            // both must hit when select is 3
            assign data_hit[p] = data_active && mem_valid[p] && kind_ok &&
                                 (!use_addr || a_ok) && (!use_value || v_ok);
        end
    endgenerate

    // events registered so the timer sees a clean per-cycle count
    // control cleared at reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            instr_bp_control_reg <= INSTR_CTRL_RESET;
            data_bp_control_reg  <= DATA_CTRL_RESET;
        end else if (clk_en && reg_write) begin
            if (reg_addr == OFS_INSTR_CTRL) begin
                instr_bp_control_reg <= reg_wdata[INSTR_CTRL_W-1:0];
            end
            if (reg_addr == OFS_DATA_CTRL) begin
                data_bp_control_reg <= reg_wdata[DATA_CTRL_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            instr_ev_reg   <= 1'b0;
            data_count_reg <= 2'h0;
        end else if (clk_en) begin
            instr_ev_reg   <= instr_hit;
            // summed before the flop so the count output leaves a register
            data_count_reg <= {1'b0, data_hit[0]} + {1'b0, data_hit[1]};
        end
    end

    wire [1:0] data_count  = data_count_reg;
    wire [1:0] instr_count = {1'b0, instr_ev_reg};

    assign instr_match_source = instr_ev_reg;
    assign data_match_source  = data_count;

    assign timer_increment = (timer_source == SRC_DATA_MATCH)  ? data_count :
                             (timer_source == SRC_INSTR_MATCH) ? instr_count : 2'h0;

    // total matches seen, write clears, a match in the same cycle still counts
    wire cnt_clear = reg_write && (reg_addr == OFS_MATCH_CNT);
    wire [DATA_W-1:0] cnt_add = {{(DATA_W-2){1'b0}}, data_count} + {{(DATA_W-2){1'b0}}, instr_count};
    assign match_cnt_next = (cnt_clear ? '0 : match_cnt_reg) + cnt_add;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            match_cnt_reg <= '0;
        end else if (clk_en) begin
            match_cnt_reg <= match_cnt_next;
        end
    end

    // bound writes go to the store
    wire wr_instr_low  = reg_addr == OFS_INSTR_LOW;
    wire wr_instr_high = reg_addr == OFS_INSTR_HIGH;
    wire wr_data_low   = reg_addr == OFS_DATA_LOW;
    wire wr_data_high  = reg_addr == OFS_DATA_HIGH;
    wire wr_value      = reg_addr == OFS_DATA_VALUE;
    wire wr_mask       = reg_addr == OFS_DATA_MASK;
    assign bnd.wr_en = reg_write && (wr_instr_low || wr_instr_high || wr_data_low ||
                                     wr_data_high || wr_value || wr_mask);
    assign bnd.wr_idx = wr_instr_low  ? IDX_INSTR_LOW  :
                        wr_instr_high ? IDX_INSTR_HIGH :
                        wr_data_low   ? IDX_DATA_LOW   :
                        wr_data_high  ? IDX_DATA_HIGH  :
                        wr_value      ? IDX_DATA_VALUE : IDX_DATA_MASK;
    assign bnd.wr_data = reg_wdata;

    // read mux, unmapped addresses read zero
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            OFS_INSTR_CTRL: rd_mux = {{(DATA_W-INSTR_CTRL_W){1'b0}}, instr_bp_control_reg};
            OFS_INSTR_LOW:  rd_mux = instr_low;
            OFS_INSTR_HIGH: rd_mux = instr_high;
            OFS_DATA_CTRL:  rd_mux = {{(DATA_W-DATA_CTRL_W){1'b0}}, data_bp_control_reg};
            OFS_DATA_LOW:   rd_mux = data_low;
            OFS_DATA_HIGH:  rd_mux = data_high;
            OFS_DATA_VALUE: rd_mux = data_compare_value;
            OFS_DATA_MASK:  rd_mux = data_compare_mask;
            OFS_MATCH_CNT:  rd_mux = match_cnt_reg;
            default:        rd_mux = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_reg <= '0;
        end else if (clk_en) begin
            reg_rdata_reg <= reg_read ? rd_mux : '0;
        end
    end
    assign reg_rdata = reg_rdata_reg;
endmodule : breakpoint_match_unit

// ### tb/bp_properties.sv
// Purpose: port-level properties of the breakpoint match unit
// Assumes: events and read data register one cycle after their cause
// Notes:   shadow copies of the gating bits judge when events must stay quiet
`timescale 1ns/1ps
module bp_properties (
    input wire logic                       clk,
    input wire logic                       arst_n,
    input wire logic                       clk_en,
    input wire logic [bp_pkg::RADDR_W-1:0] reg_addr,
    input wire logic [bp_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                       reg_write,
    input wire logic                       reg_read,
    input wire logic [bp_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic                       instr_valid,
    input wire logic [bp_pkg::PORTS-1:0]   mem_valid,
    input wire logic [3:0]                 timer_source,
    input wire logic [1:0]                 timer_increment,
    input wire logic                       instr_match_source,
    input wire logic [1:0]                 data_match_source
);
    import bp_pkg::*;
    logic       ien_reg;
    logic [1:0] dsel_reg;

    // mirror of the gating bits, cleared like the real ones
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ien_reg  <= 1'b0;
            dsel_reg <= 2'h0;
        end else if (clk_en && reg_write && reg_addr == OFS_INSTR_CTRL) begin
            ien_reg <= reg_wdata[INSTR_ENABLE_BIT];
        end else if (clk_en && reg_write && reg_addr == OFS_DATA_CTRL) begin
            dsel_reg <= reg_wdata[DSEL_W-1:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    instr_gate_off_a: assert property ($past(clk_en) && !$past(ien_reg) |-> !instr_match_source)
        else $error("instruction event while disabled");
    instr_need_fetch_a: assert property ($past(clk_en) && !$past(instr_valid) |-> !instr_match_source)
        else $error("instruction event without a fetch");
    data_gate_off_a: assert property ($past(clk_en) && $past(dsel_reg) == 2'h0
        |-> data_match_source == 2'h0) else $error("data event while compare is off");
    data_count_cap_a: assert property ($past(clk_en)
        |-> data_match_source <= $countones($past(mem_valid))) else $error("more data events than accesses");
    data_src_mux_a: assert property ($stable(timer_source) && timer_source == SRC_DATA_MATCH
        |-> timer_increment == data_match_source) else $error("data source increment wrong");
    instr_src_mux_a: assert property ($stable(timer_source) && timer_source == SRC_INSTR_MATCH
        |-> timer_increment == {1'b0, instr_match_source}) else $error("instr source increment wrong");
    other_src_zero_a: assert property ($stable(timer_source) && timer_source != SRC_DATA_MATCH
        && timer_source != SRC_INSTR_MATCH |-> timer_increment == 2'h0) else $error("foreign source counted");
    rdata_idle_a: assert property ($past(clk_en) && !$past(reg_read) |-> reg_rdata == '0)
        else $error("read data outside its slot");
    ictrl_spare_a: assert property ($past(clk_en) && $past(reg_read) && $past(reg_addr) == OFS_INSTR_CTRL
        |-> reg_rdata[DATA_W-1:INSTR_CTRL_W] == '0) else $error("instr control spare bits set");
    dctrl_spare_a: assert property ($past(clk_en) && $past(reg_read) && $past(reg_addr) == OFS_DATA_CTRL
        |-> reg_rdata[DATA_W-1:DATA_CTRL_W] == '0) else $error("data control spare bits set");
endmodule : bp_properties

bind breakpoint_match_unit bp_properties i_bp_properties (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .instr_valid(instr_valid), .mem_valid(mem_valid), .timer_source(timer_source),
    .timer_increment(timer_increment), .instr_match_source(instr_match_source),
    .data_match_source(data_match_source));

// ### tb/pipeline_model.sv
// Purpose: fetch and load/store side of the processor feeding the matcher
// Assumes: one slot per call, launched just after a rising edge
// Notes:   idle buses carry the inverse of the last value, never a stale match
`timescale 1ns/1ps
module pipeline_model (
    input  wire logic                              clk,
    output logic                                   instr_valid,
    output logic [bp_pkg::ADDR_W-1:0]              instr_addr,
    output logic [bp_pkg::PORTS-1:0]               mem_valid,
    output logic [bp_pkg::PORTS-1:0]               mem_is_store,
    output logic [bp_pkg::PORTS*bp_pkg::ADDR_W-1:0] mem_addr,
    output logic [bp_pkg::PORTS*bp_pkg::DATA_W-1:0] mem_data
);
    import bp_pkg::*;
    // quiet pipeline at time zero
    initial begin
        instr_valid = 1'b0;
        instr_addr = '0;
        mem_valid = 2'h0;
        mem_is_store = 2'h0;
        mem_addr = '0;
        mem_data = '0;
    end

    // one issued fetch, then the address bus is scrambled
    task automatic fetch(input logic [31:0] a);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_addr <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_addr <= ~a;
    endtask : fetch

    // both load/store units in one cycle, port 0 in the low half
    task automatic access(input logic [1:0] v, input logic [1:0] st, input logic [63:0] a, input logic [63:0] d);
        @(posedge clk);
        mem_valid <= v;
        mem_is_store <= st;
        mem_addr <= a;
        mem_data <= d;
        @(posedge clk);
        mem_valid <= 2'h0;
        mem_addr <= ~a;
        mem_data <= ~d;
    endtask : access
endmodule : pipeline_model

// ### tb/tb_breakpoint_match_unit.sv
// Purpose: self-checking bench for the breakpoint match unit
// Assumes: events one cycle after the access, read data one cycle after the strobe
// Notes:   one scenario drops clk_en to show that a fetch leaves no trace while frozen
`timescale 1ns/1ps
module tb_breakpoint_match_unit;
    import bp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [3:0] timer_source = 4'h0;
    logic [31:0] reg_rdata, instr_addr;
    logic instr_valid, instr_match_source;
    logic [1:0] mem_valid, mem_is_store, timer_increment, data_match_source;
    logic [63:0] mem_addr, mem_data;
    int errors = 0;
    int compares = 0;

    always #4 clk = ~clk;

    breakpoint_match_unit i_breakpoint_match_unit (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr_addr(instr_addr), .mem_valid(mem_valid),
        .mem_is_store(mem_is_store), .mem_addr(mem_addr), .mem_data(mem_data), .timer_source(timer_source),
        .timer_increment(timer_increment), .instr_match_source(instr_match_source),
        .data_match_source(data_match_source));
    pipeline_model i_pipeline_model (.clk(clk), .instr_valid(instr_valid), .instr_addr(instr_addr),
        .mem_valid(mem_valid), .mem_is_store(mem_is_store), .mem_addr(mem_addr), .mem_data(mem_data));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask : rd

    task automatic itry(input logic [31:0] a, input logic e);
        i_pipeline_model.fetch(a);
        #1 chk("instr event", {31'h0, e}, {31'h0, instr_match_source});
        chk("instr increment", {31'h0, e}, {30'h0, timer_increment});
    endtask : itry

    task automatic dtry(input logic [1:0] v, input logic [63:0] a, input logic [63:0] d, input logic [1:0] e);
        i_pipeline_model.access(v, 2'b10, a, d);
        #1 chk("data events", {30'h0, e}, {30'h0, data_match_source});
        chk("data increment", {30'h0, e}, {30'h0, timer_increment});
    endtask : dtry

    // cleared controls, spare bits, unmapped hole, quiet after reset
    task automatic test_regs();
        rd(OFS_INSTR_CTRL, 32'h0, "instr control");
        rd(OFS_DATA_CTRL, 32'h0, "data control");
        rd(8'h0C, 32'h0, "unmapped");
        wr(OFS_DATA_CTRL, 32'hFFFF_FFCF);
        rd(OFS_DATA_CTRL, 32'h0000_000F, "data control");
        wr(OFS_DATA_CTRL, 32'h0);
        itry(32'h0, 1'b0);
    endtask : test_regs

    // every enable/invert combination at both bounds
    task automatic test_instr();
        logic [31:0] ia [4] = '{32'h0FF, 32'h100, 32'h1FF, 32'h200};
        timer_source <= SRC_INSTR_MATCH;
        wr(OFS_INSTR_LOW, 32'h100);
        wr(OFS_INSTR_HIGH, 32'h1FF);
        rd(OFS_INSTR_HIGH, 32'h1FF, "instr high");
        for (int m = 0; m < 4; m++) begin
            wr(OFS_INSTR_CTRL, 32'(m));
            for (int k = 0; k < 4; k++) itry(ia[k], m[0] & ((k == 1 || k == 2) ^ m[1]));
        end
        wr(OFS_INSTR_CTRL, 32'h0);
    endtask : test_instr

    // a frozen clock enable swallows a hit; a mid-run reset clears control but keeps bounds
    task automatic test_freeze();
        wr(OFS_INSTR_CTRL, 32'h1);
        clk_en <= 1'b0;
        itry(32'h100, 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        itry(32'h100, 1'b1);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_INSTR_CTRL, 32'h0, "instr control");
        rd(OFS_INSTR_LOW, 32'h100, "instr low");
    endtask : test_freeze

    // address compare per access kind, inside and outside, high aperture
    task automatic test_addr();
        logic [63:0] va [4] = '{64'h2000_0000_1000, 64'h1FFF_0000_0FFF, 64'h1000_0000_1800, 64'hFFFF_F000_0000_0000};
        logic [5:0] cs [5] = '{6'h05, 6'h09, 6'h0D, 6'h1D, 6'h0C};
        logic [7:0] ex [5] = '{8'h11, 8'h14, 8'h25, 8'h85, 8'h00};
        timer_source <= SRC_DATA_MATCH;
        wr(OFS_DATA_LOW, 32'h1000);
        wr(OFS_DATA_HIGH, 32'h1FFF);
        for (int c = 0; c < 5; c++) begin
            wr(OFS_DATA_CTRL, {26'h0, cs[c]});
            for (int v = 0; v < 4; v++) dtry(2'b11, va[v], 64'h0, ex[c][2*v +: 2]);
        end
        // inverted range, loads and stores, only port 0 issuing
        wr(OFS_DATA_CTRL, 32'h1D);
        dtry(2'b01, va[3], 64'h0, 2'h1);
    endtask : test_addr

    // masked equal and not-equal compare per access kind
    task automatic test_value();
        logic [5:0] cs [7] = '{6'h06, 6'h0A, 6'h2A, 6'h2E, 6'h0E, 6'h26, 6'h02};
        logic [6:0] ex = 7'b0011101;
        wr(OFS_DATA_VALUE, 32'h1234_5678);
        wr(OFS_DATA_MASK, 32'h0000_FF00);
        for (int c = 0; c < 7; c++) begin
            wr(OFS_DATA_CTRL, {26'h0, cs[c]});
            dtry(2'b11, 64'h1000, 64'h1234_5778_AAAA_56BB, {1'b0, ex[c]});
        end
    endtask : test_value

    // address and value must both hit on the same access; the match counter sums them
    task automatic test_both();
        wr(OFS_DATA_CTRL, 32'h0F);
        wr(OFS_MATCH_CNT, 32'h0);
        dtry(2'b11, 64'h1FFF_0000_1000, 64'h5600_AAAA_56BB, 2'h2);
        dtry(2'b11, 64'h2000_0000_1000, 64'h5600_AAAA_56BB, 2'h1);
        dtry(2'b11, 64'h1FFF_0000_1000, 64'h1234_5778_AAAA_56BB, 2'h1);
        rd(OFS_MATCH_CNT, 32'h4, "match count");
    endtask : test_both

    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        test_regs();
        test_instr();
        test_freeze();
        test_addr();
        test_value();
        test_both();
        end_of_test();
    end
endmodule : tb_breakpoint_match_unit
